// file: logic/lrdcp_core.sv
// Command decode, read and write bursts of the low latency dram port
//
// Summary of operation
// RQ1: Deselect starts nothing, running bursts continue
// RQ2: Read is select low, write and refresh high
// RQ3: Write is select and write low, refresh high
// RQ4: All low loads mode, write-only-high refreshes
// RQ5: Commands and address taken on rising clock
// RQ6: Single mode: controller sends full address
// RQ7: Split mode: second half taken next edge
// RQ8: Read data appears read latency after command
// RQ9: Data and valid aligned to echo clocks
// RQ10: Valid rises half cycle before first data; code raises it one full cycle before
// RQ11: Valid falls on the final burst beat
// RQ12: Data outputs released when burst ends idle
// RQ13: Echo clocks toggle all the time; code holds them while ce_i is low
// RQ14: Back to back reads give gapless data
// RQ15: Bad clock level holds valid until read
// RQ16: Write data taken one cycle after latency
// RQ17: Masked write beat leaves memory unchanged
// RQ18: Write data sampled on write data clock
// RQ19: Controller idles once between read and write
// RQ20: Refresh uses bank only, back to back
// RQ21: Controller waits row cycle after refresh
// RQ22: Mode load uses address bits 0 to 17
// RQ23: Split mode adds one cycle to latencies
// RQ24: Controller keeps row cycle of 3 or 4
// RQ25: Controller waits 1024 cycles after lock reset
// RQ26: Controller keeps one row timer per bank
// RQ27: Controller checks valid flag timing
`timescale 1ns/1ps
module lrdcp_core (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic                       ce_i,
  input  wire lrdcp_pkg::lrdcp_cmd_t      cmd_i,
  input  wire logic [lrdcp_pkg::DQ_W-1:0] d_i,
  input  wire logic                       write_mask_i,
  input  wire logic                       write_data_clock_i,
  input  wire logic                       ck_level_ok_i,
  output logic [lrdcp_pkg::DQ_W-1:0]      q_o,
  output logic                            q_oe_o,
  output logic                            read_valid_flag_o,
  output logic                            read_echo_clock_o,
  output logic                            read_echo_clock_b_o,
  output logic                            write_ready_o,
  output logic                            write_overrun_o,
  output logic [lrdcp_pkg::BANK_W-1:0]    refresh_bank_o,
  output logic                            refresh_pulse_o,
  output logic                            dll_reset_o
);
  import lrdcp_pkg::*;

  lrdcp_st_t        s_q;
  lrdcp_st_t        s_d;
  lrdcp_op_t        op;
  lrdcp_slot_t      slot;
  logic [3:0]       rl;
  logic [3:0]       bl;
  logic [3:0]       rleft_now;
  logic [IDX_W-1:0] ridx_now;
  logic             launch;
  logic             early;
  logic             wstart;
  logic             beat;
  logic             dk_edge;
  logic             take;
  logic             drain;
  logic             mem_we;
  logic [DQ_W-1:0]  mem [MEM_D];

  // Command pin decode
  function automatic lrdcp_op_t f_decode(input lrdcp_cmd_t c);
    if (c.cs_b) begin
      return OP_IDLE;
    end
    case ({c.we_b, c.ref_b})
      2'b00:   return OP_MODE;
      2'b11:   return OP_READ;
      2'b01:   return OP_WRITE;
      2'b10:   return OP_REF;
      default: return OP_IDLE;
    endcase
  endfunction

  // Read latency from mode field
  function automatic logic [3:0] f_rl(input logic [MR_W-1:0] m);
    return RL_BASE + {1'b0, m[MR_RL_LSB+:3]};
  endfunction

  // Burst length from mode field
  function automatic logic [3:0] f_bl(input logic [MR_W-1:0] m);
    case (m[MR_BL_LSB+:2])
      2'b00:   return BL_2;
      2'b01:   return BL_4;
      default: return BL_8;
    endcase
  endfunction

  // Next word inside the same bank
  function automatic logic [IDX_W-1:0] f_next(input logic [IDX_W-1:0] i);
    return {i[IDX_W-1:4], i[3:0] + 4'h1};
  endfunction

  // Next state of the whole port
  always_comb begin
    s_d       = s_q;
    slot      = '0;
    op        = OP_IDLE;
    rl        = f_rl(s_q.mode);
    bl        = f_bl(s_q.mode);
    rleft_now = s_q.rleft;
    ridx_now  = s_q.ridx;
    beat      = 1'b0;
    take      = 1'b0;
    s_d.rpulse = 1'b0;
    // Input synchronisers
    s_d.dk     = {s_q.dk[1:0], write_data_clock_i};
    s_d.dsy[0] = d_i;
    s_d.dsy[1] = s_q.dsy[0];
    s_d.msy    = {s_q.msy[0], write_mask_i};
    s_d.ok     = {s_q.ok[0], ck_level_ok_i};
    dk_edge    = s_q.dk[1] & ~s_q.dk[2]; // see RQ18
    // Command slot, second half or fresh decode
    if (s_q.phase == PH_TWO) begin
      slot.vld  = 1'b1;
      slot.wr   = s_q.ph_wr;
      slot.idx  = {s_q.ph_bank, cmd_i.addr[1:0], s_q.ph_ax}; // see RQ7
      s_d.phase = PH_ONE;
    end else begin
      op = f_decode(cmd_i); // see RQ1
      case (op)
        OP_MODE: begin
          s_d.mode = cmd_i.addr[MR_W-1:0]; // see RQ4 see RQ22
        end
        OP_READ, OP_WRITE: begin
          if (s_q.mode[MR_SPLIT]) begin
            s_d.phase   = PH_TWO; // see RQ23
            s_d.ph_wr   = (op == OP_WRITE);
            s_d.ph_bank = cmd_i.bank;
            s_d.ph_ax   = cmd_i.addr[1:0];
          end else begin
            slot.vld = 1'b1; // see RQ2 see RQ3
            slot.wr  = (op == OP_WRITE);
            slot.idx = {cmd_i.bank, cmd_i.addr[3:0]}; // see RQ5
          end
        end
        OP_REF: begin
          s_d.rbank  = cmd_i.bank; // see RQ20
          s_d.rpulse = 1'b1;
        end
        default: ;
      endcase
    end
    // Latency line shared by reads and writes
    s_d.pipe[PIPE_D-1:1] = s_q.pipe[PIPE_D-2:0];
    s_d.pipe[0]          = slot;
    launch = s_q.pipe[rl-4'h1].vld & ~s_q.pipe[rl-4'h1].wr; // see RQ8
    early  = s_q.pipe[rl-4'h2].vld & ~s_q.pipe[rl-4'h2].wr;
    wstart = s_q.pipe[rl].vld & s_q.pipe[rl].wr; // see RQ16
    // Read burst; a new launch takes over any beats still left
    if (launch) begin
      rleft_now = bl; // see RQ14
      ridx_now  = s_q.pipe[rl-4'h1].idx;
    end
    if (rleft_now != 4'h0) begin
      beat      = 1'b1;
      s_d.q     = mem[ridx_now];
      s_d.ridx  = f_next(ridx_now);
      s_d.rleft = rleft_now - 4'h1;
    end
    s_d.qoe   = beat; // see RQ12
    s_d.stuck = (s_q.stuck | (~s_q.ok[1] & s_q.vld)) & (op != OP_READ); // see RQ15
    s_d.vld   = early | (beat & (rleft_now > 4'h1)) | s_d.stuck; // see RQ10 see RQ11
    s_d.echo   = ~s_q.echo; // see RQ13
    s_d.echo_b = s_q.echo; // see RQ9
    // Write window counts write clock edges
    if (wstart) begin
      s_d.wleft = bl;
      s_d.widx  = s_q.pipe[rl].idx;
    end else if ((s_q.wleft != 4'h0) && dk_edge) begin
      take      = 1'b1; // see RQ18
      s_d.wleft = s_q.wleft - 4'h1;
      s_d.widx  = f_next(s_q.widx);
    end
    // Two entry buffer, drained when the array is free
    drain  = (s_q.cnt != 2'h0) & ~beat;
    mem_we = drain & ~s_q.fifo[s_q.rp].mask; // see RQ17
    if (drain) begin
      s_d.rp = ~s_q.rp;
    end
    if (take && (s_q.cnt != 2'h2)) begin
      s_d.fifo[s_q.wp] = '{idx: s_q.widx, data: s_q.dsy[1], mask: s_q.msy[1]};
      s_d.wp           = ~s_q.wp;
    end else if (take) begin
      s_d.ovr = 1'b1;
    end
    case ({take && (s_q.cnt != 2'h2), drain})
      2'b10:   s_d.cnt = s_q.cnt + 2'h1;
      2'b01:   s_d.cnt = s_q.cnt - 2'h1;
      default: s_d.cnt = s_q.cnt;
    endcase
    s_d.wrdy = (s_d.cnt != 2'h2);
  end

  // State register, frozen while the enable is low
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q      <= '0;
      s_q.mode <= MODE_RST;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // Storage array write port
  always_ff @(posedge clock_i) begin
    if (ce_i && mem_we) begin
      mem[s_q.fifo[s_q.rp].idx] <= s_q.fifo[s_q.rp].data;
    end
  end

  // Outputs straight from state
  assign q_o                 = s_q.q;
  assign q_oe_o              = s_q.qoe;
  assign read_valid_flag_o   = s_q.vld;
  assign read_echo_clock_o   = s_q.echo;
  assign read_echo_clock_b_o = s_q.echo_b;
  assign write_ready_o       = s_q.wrdy;
  assign write_overrun_o     = s_q.ovr;
  assign refresh_bank_o      = s_q.rbank;
  assign refresh_pulse_o     = s_q.rpulse;
  assign dll_reset_o         = s_q.mode[MR_DLL];

  // Checks on the port behaviour
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i || !ce_i);

  sequence s_split_cmd;
    !cmd_i.cs_b && cmd_i.ref_b && s_q.phase == PH_ONE && s_q.mode[MR_SPLIT];
  endsequence

  sequence s_second_slot(logic [1:0] ax);
    !s_q.pipe[0].vld ##1 (s_q.pipe[0].vld && s_q.pipe[0].idx[1:0] == ax);
  endsequence

  idle_no_start_a: assert property ( // see RQ1
    cmd_i.cs_b && s_q.phase == PH_ONE |=> !s_q.pipe[0].vld)
    else $error("deselect started an operation");

  read_decode_a: assert property ( // see RQ2
    !cmd_i.cs_b && cmd_i.we_b && cmd_i.ref_b && s_q.phase == PH_ONE && !s_q.mode[MR_SPLIT]
    |=> s_q.pipe[0].vld && !s_q.pipe[0].wr)
    else $error("read not decoded");

  write_decode_a: assert property ( // see RQ3
    !cmd_i.cs_b && !cmd_i.we_b && cmd_i.ref_b && s_q.phase == PH_ONE && !s_q.mode[MR_SPLIT]
    |=> s_q.pipe[0].vld && s_q.pipe[0].wr)
    else $error("write not decoded");

  mode_load_a: assert property ( // see RQ22
    !cmd_i.cs_b && !cmd_i.we_b && !cmd_i.ref_b && s_q.phase == PH_ONE
    |=> s_q.mode == $past(cmd_i.addr[MR_W-1:0]))
    else $error("mode not loaded from low address bits");

  property p_split_join;
    logic [1:0] ax_v;
    (s_split_cmd, ax_v = cmd_i.addr[1:0]) |=> s_second_slot(ax_v);
  endproperty

  split_second_a: assert property (p_split_join) // see RQ7
    else $error("split address not joined");

  read_launch_a: assert property ( // see RQ8
    s_q.pipe[f_rl(s_q.mode)-4'h1].vld && !s_q.pipe[f_rl(s_q.mode)-4'h1].wr |=> s_q.qoe)
    else $error("read data not launched at latency");

  valid_early_a: assert property ( // see RQ10
    $rose(s_q.vld) && !s_q.stuck |=> s_q.qoe)
    else $error("valid not one step ahead of data");

  valid_last_a: assert property ( // see RQ11
    $fell(s_q.qoe) && !s_q.stuck |-> !s_q.vld && !$past(s_q.vld))
    else $error("valid still high on final beat");

  echo_toggle_a: assert property ( // see RQ13
    $past(ce_i) && $past(rst_b_i) |-> s_q.echo != $past(s_q.echo) && s_q.echo_b == $past(s_q.echo))
    else $error("echo clocks stopped");

  stuck_hold_a: assert property ( // see RQ15
    s_q.stuck && !(s_q.phase == PH_ONE && !cmd_i.cs_b && cmd_i.we_b && cmd_i.ref_b) |=> s_q.vld)
    else $error("valid dropped without a read");

  mask_keep_a: assert property ( // see RQ17
    s_q.cnt != 2'h0 && s_q.fifo[s_q.rp].mask |-> !mem_we)
    else $error("masked beat written");

  refresh_bank_a: assert property ( // see RQ20
    !cmd_i.cs_b && cmd_i.we_b && !cmd_i.ref_b && s_q.phase == PH_ONE
    |=> s_q.rpulse && s_q.rbank == $past(cmd_i.bank))
    else $error("refresh not taken from bank pins");

  read_index_a: assert property ( // see RQ5
    !cmd_i.cs_b && cmd_i.ref_b && s_q.phase == PH_ONE && !s_q.mode[MR_SPLIT]
    |=> s_q.pipe[0].idx == {$past(cmd_i.bank), $past(cmd_i.addr[3:0])})
    else $error("command address not captured");

  split_phase_a: assert property ( // see RQ23
    s_split_cmd |=> s_q.phase == PH_TWO)
    else $error("split command took no second cycle");

  gapless_read_a: assert property ( // see RQ14
    s_q.qoe && s_q.rleft == 4'h0 && launch |=> s_q.qoe)
    else $error("gap between joined read bursts");

  data_release_a: assert property ( // see RQ12
    s_q.rleft == 4'h0 && !launch |=> !s_q.qoe)
    else $error("read outputs not released");

  echo_pair_a: assert property ( // see RQ9
    $past(ce_i) && $past(rst_b_i) |-> s_q.echo_b != s_q.echo)
    else $error("echo clocks not complementary");

  write_window_a: assert property ( // see RQ16
    s_q.pipe[f_rl(s_q.mode)].vld && s_q.pipe[f_rl(s_q.mode)].wr
    |=> s_q.wleft == f_bl($past(s_q.mode)))
    else $error("write window not opened after latency");

  beat_on_edge_a: assert property ( // see RQ18
    s_q.wleft != 4'h0 && !wstart && !(s_q.dk[1] && !s_q.dk[2]) |=> s_q.wleft == $past(s_q.wleft))
    else $error("write beat taken without data clock edge");

  write_back_a: assert property ( // see RQ17
    s_q.cnt != 2'h0 && !s_q.fifo[s_q.rp].mask && !beat |-> mem_we)
    else $error("unmasked beat not written");

  stuck_set_a: assert property ( // see RQ15
    !s_q.ok[1] && s_q.vld && !(s_q.phase == PH_ONE && !cmd_i.cs_b && cmd_i.we_b && cmd_i.ref_b)
    |=> s_q.stuck)
    else $error("valid not held on bad clock level");

  stuck_clear_a: assert property ( // see RQ15
    s_q.phase == PH_ONE && !cmd_i.cs_b && cmd_i.we_b && cmd_i.ref_b |=> !s_q.stuck)
    else $error("dummy read did not clear held valid");
endmodule

// file: logic/lrdcp_pkg.sv
// Constants and types for the low latency dram command port
package lrdcp_pkg;
  localparam int unsigned BANK_W = 3;
  localparam int unsigned ADDR_W = 22;
  localparam int unsigned MR_W   = 18;
  localparam int unsigned DQ_W   = 9;
  localparam int unsigned IDX_W  = 7;
  localparam int unsigned MEM_D  = 128;
  localparam int unsigned PIPE_D = 12;
  localparam logic [MR_W-1:0] MODE_RST = 18'h00000;
  localparam int unsigned MR_RL_LSB = 0;
  localparam int unsigned MR_BL_LSB = 3;
  localparam int unsigned MR_SPLIT  = 5;
  localparam int unsigned MR_DLL    = 7;
  localparam logic [3:0] RL_BASE = 4'h3;
  localparam logic [3:0] BL_2    = 4'h2;
  localparam logic [3:0] BL_4    = 4'h4;
  localparam logic [3:0] BL_8    = 4'h8;

  typedef enum logic [2:0] {
    OP_IDLE  = 3'b000,
    OP_MODE  = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b011,
    OP_REF   = 3'b100
  } lrdcp_op_t;

  typedef enum logic {
    PH_ONE = 1'b0,
    PH_TWO = 1'b1
  } lrdcp_ph_t;

  typedef struct packed {
    logic              cs_b;
    logic              we_b;
    logic              ref_b;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } lrdcp_cmd_t;

  typedef struct packed {
    logic             vld;
    logic             wr;
    logic [IDX_W-1:0] idx;
  } lrdcp_slot_t;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic [DQ_W-1:0]  data;
    logic             mask;
  } lrdcp_beat_t;

  typedef struct packed {
    logic [MR_W-1:0]               mode;
    lrdcp_ph_t                     phase;
    logic                          ph_wr;
    logic [BANK_W-1:0]             ph_bank;
    logic [1:0]                    ph_ax;
    lrdcp_slot_t [PIPE_D-1:0]      pipe;
    logic [3:0]                    rleft;
    logic [IDX_W-1:0]              ridx;
    logic [DQ_W-1:0]               q;
    logic                          qoe;
    logic                          vld;
    logic                          stuck;
    logic                          echo;
    logic                          echo_b;
    logic [3:0]                    wleft;
    logic [IDX_W-1:0]              widx;
    logic [2:0]                    dk;
    logic [1:0][DQ_W-1:0]          dsy;
    logic [1:0]                    msy;
    logic [1:0]                    ok;
    lrdcp_beat_t [1:0]             fifo;
    logic                          wp;
    logic                          rp;
    logic [1:0]                    cnt;
    logic                          wrdy;
    logic                          ovr;
    logic [BANK_W-1:0]             rbank;
    logic                          rpulse;
  } lrdcp_st_t;
endpackage

// file: dv/lrdcp_ctrl_model.sv
// Memory controller model: commands and write bursts
`timescale 1ns/1ps
module lrdcp_ctrl_model (
  input  wire logic                  clock_i,
  output lrdcp_pkg::lrdcp_cmd_t      cmd_o,
  output logic [lrdcp_pkg::DQ_W-1:0] d_o,
  output logic                       write_mask_o,
  output logic                       write_data_clock_o
);
  import lrdcp_pkg::*;

  // Idle bus at start, data clock parked low
  initial begin
    cmd_o = '{cs_b: 1'b1, we_b: 1'b1, ref_b: 1'b1, bank: '0, addr: '0};
    d_o = '0;
    write_mask_o = 1'b0;
    write_data_clock_o = 1'b0;
  end

  // One command for one edge, or two edges in split mode, then deselect
  task automatic send(input lrdcp_cmd_t c, input logic split, input logic [1:0] ay);
    @(negedge clock_i);
    cmd_o = c;
    if (split) begin
      @(negedge clock_i);
      cmd_o = '{cs_b: 1'b0, we_b: 1'b0, ref_b: 1'b0, bank: ~c.bank, addr: {20'hFFFFF, ay}};
    end
    @(negedge clock_i);
    cmd_o = '{cs_b: 1'b1, we_b: c.we_b, ref_b: c.ref_b, bank: c.bank, addr: ~c.addr};
  endtask

  // Two refreshes on consecutive edges, then row cycle wait
  task automatic refresh(input logic [2:0] b0, input logic [2:0] b1);
    @(negedge clock_i);
    cmd_o = '{cs_b: 1'b0, we_b: 1'b1, ref_b: 1'b0, bank: b0, addr: '1};
    @(negedge clock_i);
    cmd_o.bank = b1;
    @(negedge clock_i);
    cmd_o.cs_b = 1'b1;
    repeat (4) @(negedge clock_i);
  endtask

  // Write beats, one per 80 ns data clock period, driven on falling edges
  task automatic burst(input logic [DQ_W-1:0] d [8], input logic [7:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      d_o = d[i];
      write_mask_o = m[i];
      repeat (4) @(negedge clock_i);
      write_data_clock_o = 1'b1;
      repeat (4) @(negedge clock_i);
      write_data_clock_o = 1'b0;
    end
    d_o = ~d_o; // Released lines do not keep their value
    write_mask_o = ~write_mask_o;
  endtask
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the dram command port
`timescale 1ns/1ps
module tb_top;
  import lrdcp_pkg::*;
  logic              clock_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic              ce_i    = 1'b1;
  logic              ck_ok   = 1'b1;
  lrdcp_cmd_t        cmd;
  logic [DQ_W-1:0]   d, q;
  logic              mask, dk, q_oe, vld, echo, echo_b, wrdy, ovr, rpulse, dll;
  logic [BANK_W-1:0] rbank;
  logic [DQ_W-1:0]   mem [MEM_D];
  logic [MR_W-1:0]   mode = MODE_RST;
  int                err_count = 0;
  int                samples_checked = 0;

  // Main clock
  always #5 clock_i = ~clock_i;

  lrdcp_core u_lrdcp_core (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cmd_i(cmd), .d_i(d),
    .write_mask_i(mask), .write_data_clock_i(dk), .ck_level_ok_i(ck_ok), .q_o(q), .q_oe_o(q_oe),
    .read_valid_flag_o(vld), .read_echo_clock_o(echo), .read_echo_clock_b_o(echo_b), .write_ready_o(wrdy),
    .write_overrun_o(ovr), .refresh_bank_o(rbank), .refresh_pulse_o(rpulse), .dll_reset_o(dll));

  lrdcp_ctrl_model u_lrdcp_ctrl_model (.clock_i(clock_i), .cmd_o(cmd), .d_o(d), .write_mask_o(mask),
    .write_data_clock_o(dk));

  // Latency and burst length from a mode word
  function automatic int rl_of(input logic [MR_W-1:0] m);
    return int'(RL_BASE) + int'(m[2:0]) + int'(m[5]);
  endfunction
  function automatic int bl_of(input logic [MR_W-1:0] m);
    return (m[4:3] == 2'h0) ? 2 : (m[4:3] == 2'h1) ? 4 : 8;
  endfunction
  function automatic lrdcp_cmd_t rdc(input logic [2:0] b, input logic [3:0] w);
    return '{cs_b: 1'b0, we_b: 1'b1, ref_b: 1'b1, bank: b, addr: {18'($urandom), w}};
  endfunction

  // Comparisons
  task automatic chk_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [DQ_W-1:0] exp, input logic [DQ_W-1:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read n bursts back to back, checking every cycle
  task automatic rd(input logic [2:0] b, input logic [3:0] w, input int n);
    int rl;
    int bl;
    logic e;
    rl = rl_of(mode);
    bl = bl_of(mode);
    fork
      for (int i = 0; i < n; i++) begin
        u_lrdcp_ctrl_model.send(rdc(b, 4'(w + i * bl)), mode[5], w[3:2]);
        repeat (bl - 2) @(negedge clock_i);
      end
      begin
        @(negedge clock_i);
        e = echo;
        for (int c = 0; c <= rl + n * bl; c++) begin
          @(negedge clock_i);
          chk_bit("valid", c >= rl - 1 && c <= rl + n * bl - 2, vld);
          chk_bit("output enable", c >= rl && c < rl + n * bl, q_oe);
          if (c >= rl && c < rl + n * bl) chk_word("read data", mem[{b, 4'(w + c - rl)}], q);
          chk_bit("echo toggles", ~e, echo);
          chk_bit("echo pair", ~echo, echo_b);
          e = echo;
        end
      end
    join
  endtask

  // Write one burst with a beat mask, track expected memory
  task automatic wr(input logic [2:0] b, input logic [3:0] w, input logic [7:0] m);
    logic [DQ_W-1:0] dat [8];
    foreach (dat[i]) dat[i] = DQ_W'($urandom);
    u_lrdcp_ctrl_model.send('{cs_b: 1'b0, we_b: 1'b0, ref_b: 1'b1, bank: b, addr: {18'($urandom), w}},
      mode[5], w[3:2]);
    repeat (rl_of(mode) + 1) @(negedge clock_i);
    u_lrdcp_ctrl_model.burst(dat, m, bl_of(mode));
    for (int i = 0; i < bl_of(mode); i++) if (!m[i]) mem[{b, 4'(w + i)}] = dat[i];
    repeat (6) @(negedge clock_i);
    chk_bit("write ready", 1'b1, wrdy);
    chk_bit("no overrun", 1'b0, ovr);
  endtask

  // Mode load with random upper address bits
  task automatic ml(input logic [MR_W-1:0] m);
    u_lrdcp_ctrl_model.send('{cs_b: 1'b0, we_b: 1'b0, ref_b: 1'b0, bank: 3'($urandom),
      addr: {4'($urandom), m}}, 1'b0, 2'h0);
    mode = m;
    @(negedge clock_i);
    chk_bit("lock reset bit", m[7], dll);
    repeat (m[7] ? 1030 : 4) @(negedge clock_i);
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    #300000;
    err_count++;
    stop_test();
  end

  // Main sequence
  initial begin
    logic [2:0] b;
    logic [3:0] w;
    logic fr;
    void'($urandom(32'h9e43));
    repeat (4) @(negedge clock_i);
    chk_bit("ready in reset", 1'b0, wrdy);
    rst_b_i = 1'b1;
    @(negedge clock_i);
    chk_bit("ready after reset", 1'b1, wrdy);
    b = 3'($urandom);
    fork
      u_lrdcp_ctrl_model.refresh(b, ~b);
      begin
        repeat (2) @(negedge clock_i);
        chk_bit("first refresh", 1'b1, rpulse && rbank === b);
        @(negedge clock_i);
        chk_bit("second refresh", 1'b1, rpulse && rbank === ~b);
        @(negedge clock_i);
        chk_bit("refresh end", 1'b0, rpulse);
      end
    join
    u_lrdcp_ctrl_model.send('{cs_b: 1'b1, we_b: 1'b1, ref_b: 1'b0, bank: b, addr: 22'($urandom)}, 1'b0, 2'h0);
    repeat (8) begin
      chk_bit("deselect idle", 1'b0, q_oe || rpulse);
      @(negedge clock_i);
    end
    fr = echo;
    ce_i = 1'b0;
    repeat (3) begin
      @(negedge clock_i);
      chk_bit("frozen echo", fr, echo);
    end
    ce_i = 1'b1;
    ck_ok = 1'b0;
    u_lrdcp_ctrl_model.send(rdc(b, 4'h0), 1'b0, 2'h0);
    repeat (8) @(negedge clock_i);
    chk_bit("held valid", 1'b1, vld);
    ck_ok = 1'b1;
    repeat (4) @(negedge clock_i);
    u_lrdcp_ctrl_model.send(rdc(b, 4'h0), 1'b0, 2'h0);
    repeat (8) @(negedge clock_i);
    chk_bit("valid released", 1'b0, vld);
    for (int k = 0; k < 6; k++) begin
      if (k > 0) ml((18'($urandom) & 18'h3FF7F) | (k == 1 ? 18'h00080 : 18'h00000));
      b = 3'($urandom);
      w = 4'($urandom);
      wr(b, w, 8'h00);
      wr(b, 4'(w + bl_of(mode)), 8'h00);
      wr(b, w, 8'($urandom));
      rd(b, w, mode[5] ? 1 : 2);
    end
    stop_test();
  end
endmodule
